// [rtl/rii_receive_input.v]
// Receive input interface: converter FIFOs, delay lines, power meters
`timescale 1ns/100ps
`include "rii_defines.vh"
//
// Contract
// - Offset binary flag flips sample MSB
// - Top bit place shifts sample up
// - Eight-stage FIFO written each converter edge
// - Sync sets write four ahead of read
// - Read rate full, half, quarter, eighth
// - Skip flag captures directly on receive clock
// - Pair locks share pointers of paired ports
// - FIFO sync taken from picked source
// - I and Q streams mapped per meter
// - Test bus drives third, fourth ports
// - Each output delayed 1 to 64 samples
// - Downconverter sync from picked source
// - Square I, plus Q, into 58 bits
// - Integrate N times 8 plus 1 samples
// - Interval restarts integration every period
// - Start after 8 times delay plus 2
// - Result latched and event raised
// - Meters keep independent counters and syncs
// - Complex flag adds Q, on flag runs
// - Gated reads tolerate any clock phase
module rii_receive_input (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Converter ports
    input wire [3:0] adcClk,
    input wire [63:0] adcData,
    // Sync sources
    input wire [7:0] syncPins,
    // Input format and FIFO control
    input wire [3:0] unsignedFormatFlag,
    input wire [11:0] topBitPlace,
    input wire [1:0] fifoSpeedChoice,
    input wire fifoSkipFlag,
    input wire pairLockFirst,
    input wire pairLockSecond,
    input wire [2:0] fifoSyncPick,
    input wire [2:0] downconverterSyncPick,
    input wire [23:0] delayLength,
    // Test bus on third and fourth ports
    input wire testBusOn,
    input wire testBusPick,
    output reg [31:0] testBusData_ff,
    output wire testBusOe,
    // Power meter control
    input wire [3:0] meterOnFlag,
    input wire [3:0] meterComplexFlag,
    input wire [7:0] meterISel,
    input wire [7:0] meterQSel,
    input wire [83:0] integrationLength,
    input wire [83:0] meterRepeatInterval,
    input wire [35:0] meterStartDelay,
    input wire [11:0] meterSyncPick,
    // Power meter results
    output wire [231:0] powerResult,
    output wire [3:0] powerReady,
    // Downconverter sync and sample stream
    output reg downconverterSync_ff,
    output wire dataValid,
    input wire dataReady,
    output wire [63:0] dataOut
);
    // Synchronised sync pins and their rising edges
    reg [7:0] syncMeta_ff;
    reg [7:0] syncSync_ff;
    reg [7:0] syncPrev_ff;
    wire [7:0] syncEdge;
    wire fifoSyncEdge;
    // Read rate divider and stream control
    reg [2:0] divCnt_ff;
    reg [2:0] rateMask;
    wire rateTick;
    wire readEn;
    wire obReady;
    reg pushValid_ff;
    reg [5:0] obFill_ff; // Words held in the output buffer
    wire obPush;
    wire obPop;
    wire [6:0] obLoad; // Held words plus the pending push
    // Per-port write edges and sample buses
    wire [3:0] wrEdge;
    wire [3:0] wrEdgeEff;
    wire [63:0] fmtBus;
    wire [63:0] dlyBus;
    wire [11:0] rdPtrBus;
    wire [11:0] wrPtrBus;

    // Two-stage sync pin capture; only the second stage feeds logic
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncMeta_ff <= 8'h00;
            syncSync_ff <= 8'h00;
            syncPrev_ff <= 8'h00;
        end else begin
            syncMeta_ff <= syncPins;
            syncSync_ff <= syncMeta_ff;
            syncPrev_ff <= syncSync_ff;
        end
    end
    assign syncEdge = syncSync_ff & ~syncPrev_ff;
    assign fifoSyncEdge = syncEdge[fifoSyncPick];

    // Downconverter sync pulse from its own picked source
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            downconverterSync_ff <= 1'b0;
        end else begin
            downconverterSync_ff <= syncEdge[downconverterSyncPick];
        end
    end

    // Rate mask from the speed choice
    always @* begin
        case (fifoSpeedChoice)
            2'h0: rateMask = `RII_MASK_D1;
            2'h1: rateMask = `RII_MASK_D2;
            2'h2: rateMask = `RII_MASK_D4;
            2'h3: rateMask = `RII_MASK_D8;
            default: rateMask = `RII_MASK_D1;
        endcase
    end

    // Read divider, realigned by the FIFO sync
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_ff <= 3'h0;
        end else if (fifoSyncEdge) begin
            divCnt_ff <= 3'h0;
        end else begin
            divCnt_ff <= divCnt_ff + 3'h1;
        end
    end
    assign rateTick = ((divCnt_ff & rateMask) == 3'h0);

    // Mirror of the buffer fill; a read is issued only when its word and
    // the one still pending will find room, so full rate needs no gap
    assign obPush = pushValid_ff & obReady;
    assign obPop = dataValid & dataReady;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            obFill_ff <= 6'h00;
        end else begin
            obFill_ff <= obFill_ff + {5'h00, obPush} - {5'h00, obPop};
        end
    end
    assign obLoad = {1'b0, obFill_ff} + {6'h00, pushValid_ff};
    assign readEn = rateTick & (obLoad < `RII_OB_ROOM);

    // Push follows each read by one cycle (delay line output)
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pushValid_ff <= 1'b0;
        end else begin
            pushValid_ff <= readEn;
        end
    end

    // Paired ports advance on the lead port's edge
    assign wrEdgeEff[0] = wrEdge[0];
    assign wrEdgeEff[1] = pairLockFirst ? wrEdge[0] : wrEdge[1];
    assign wrEdgeEff[2] = wrEdge[2];
    assign wrEdgeEff[3] = pairLockSecond ? wrEdge[2] : wrEdge[3];

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gPort
            // Converter clock and data capture
            reg clkMeta_ff;
            reg clkSync_ff;
            reg clkPrev_ff;
            reg [15:0] datMeta_ff;
            reg [15:0] datSync_ff;
            // Receive FIFO
            reg [15:0] mem [0:7];
            reg [2:0] wp_ff;
            reg [2:0] rp_ff;
            // Delay line
            reg [15:0] dly [0:63];
            reg [5:0] dp_ff;
            reg [15:0] dOut_ff;
            wire [15:0] raw;
            wire [15:0] shifted;
            wire [5:0] dLen;

            // The converter clock is only sampled; data waits two
            // stages too so it lines up with the detected edge
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    clkMeta_ff <= 1'b0;
                    clkSync_ff <= 1'b0;
                    clkPrev_ff <= 1'b0;
                    datMeta_ff <= 16'h0000;
                    datSync_ff <= 16'h0000;
                end else begin
                    clkMeta_ff <= adcClk[g];
                    clkSync_ff <= clkMeta_ff;
                    clkPrev_ff <= clkSync_ff;
                    datMeta_ff <= adcData[g*16 +: 16];
                    datSync_ff <= datMeta_ff;
                end
            end
            assign wrEdge[g] = clkSync_ff & ~clkPrev_ff;

            // FIFO storage write on each converter rising edge
            always @(posedge sys_clk) begin
                if (wrEdgeEff[g]) begin
                    mem[wp_ff] <= datSync_ff;
                end
            end

            // Pointers wrap naturally at eight; sync reloads them
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    wp_ff <= `RII_RP_INIT;
                    rp_ff <= `RII_RP_INIT;
                end else if (fifoSyncEdge) begin
                    wp_ff <= `RII_WP_INIT;
                    rp_ff <= `RII_RP_INIT;
                end else begin
                    if (wrEdgeEff[g]) begin
                        wp_ff <= wp_ff + 3'h1;
                    end
                    if (readEn && !fifoSkipFlag) begin
                        rp_ff <= rp_ff + 3'h1;
                    end
                end
            end
            assign rdPtrBus[g*3 +: 3] = rp_ff;
            assign wrPtrBus[g*3 +: 3] = wp_ff;

            // Bypass takes the pin sample straight; test bus mutes
            // the third and fourth ports as inputs
            assign raw = (testBusOn && g >= 2) ? 16'h0000 :
                fifoSkipFlag ? datSync_ff : mem[rp_ff];
            assign shifted = raw << topBitPlace[g*3 +: 3];
            assign fmtBus[g*16 +: 16] = {shifted[15] ^ unsignedFormatFlag[g],
                shifted[14:0]};

            // Field value 0 means 64; slot dp-len holds that old sample
            assign dLen = delayLength[g*6 +: 6];
            always @(posedge sys_clk) begin
                if (readEn) begin
                    dly[dp_ff] <= fmtBus[g*16 +: 16];
                end
            end
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    dp_ff <= 6'h00;
                    dOut_ff <= 16'h0000;
                end else if (readEn) begin
                    dp_ff <= dp_ff + 6'h01;
                    dOut_ff <= dly[dp_ff - dLen];
                end
            end
            assign dlyBus[g*16 +: 16] = dOut_ff;
        end
    endgenerate

    // Test bus capture: samples or FIFO pointers
    assign testBusOe = testBusOn;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            testBusData_ff <= 32'h00000000;
        end else if (!testBusPick) begin
            testBusData_ff <= fmtBus[31:0];
        end else begin
            testBusData_ff <= {8'h00, wrPtrBus, rdPtrBus};
        end
    end

    // Output sample buffer toward the downconverters
    rii_fifo #(
        .WIDTH(`RII_OB_WIDTH),
        .DEPTH(`RII_OB_DEPTH),
        .AW(`RII_OB_AW)
    ) uBuffer (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .inValid(pushValid_ff),
        .inReady(obReady),
        .inData(dlyBus),
        .outValid(dataValid),
        .outReady(dataReady),
        .outData(dataOut)
    );

    genvar m;
    generate
        for (m = 0; m < 4; m = m + 1) begin : gMeter
            // Meter state, counters and result
            reg [1:0] st_ff;
            reg [`RII_DLY_W-1:0] dCnt_ff;
            reg [`RII_CNT_W-1:0] iCnt_ff;
            reg [`RII_CNT_W-1:0] vCnt_ff;
            reg [`RII_ACC_W-1:0] acc_ff;
            reg [`RII_ACC_W-1:0] res_ff;
            reg done_ff;
            wire [1:0] iSel;
            wire [1:0] qSel;
            wire signed [15:0] iS;
            wire signed [15:0] qS;
            wire signed [31:0] iSq;
            wire signed [31:0] qSq;
            wire [`RII_ACC_W-1:0] pwr;
            wire [`RII_ACC_W-1:0] accNext;
            wire [`RII_DLY_W-1:0] dTarget;
            wire [`RII_CNT_W-1:0] iTarget;
            wire [`RII_CNT_W-1:0] vTarget;
            wire mSync;

            // Per-meter I and Q source from the four formatted ports
            assign iSel = meterISel[m*2 +: 2];
            assign qSel = meterQSel[m*2 +: 2];
            assign iS = fmtBus[iSel*16 +: 16];
            assign qS = meterComplexFlag[m] ? fmtBus[qSel*16 +: 16] :
                16'h0000;
            assign iSq = iS * iS;
            assign qSq = qS * qS;
            assign pwr = {26'h0000000, iSq[31:0]} +
                {26'h0000000, qSq[31:0]};
            assign accNext = acc_ff + pwr;

            // Targets in samples; step of eight is a three-bit shift
            assign dTarget = {meterStartDelay[m*9 +: 9], `RII_STEP_SH} +
                `RII_DLY_EXTRA;
            assign iTarget = {integrationLength[m*21 +: 21], `RII_STEP_SH};
            assign vTarget = {meterRepeatInterval[m*21 +: 21], `RII_STEP_SH};
            assign mSync = syncEdge[meterSyncPick[m*3 +: 3]];

            // Meter sequencer: idle, start delay, integrate, wait
            // An interval not above the length is missed in wait until the 24-bit count wraps
            always @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    st_ff <= `RII_M_IDLE;
                    dCnt_ff <= {`RII_DLY_W{1'b0}};
                    iCnt_ff <= {`RII_CNT_W{1'b0}};
                    vCnt_ff <= {`RII_CNT_W{1'b0}};
                    acc_ff <= {`RII_ACC_W{1'b0}};
                    res_ff <= {`RII_ACC_W{1'b0}};
                    done_ff <= 1'b0;
                end else begin
                    done_ff <= 1'b0;
                    if (!meterOnFlag[m]) begin
                        st_ff <= `RII_M_IDLE;
                    end else if (mSync) begin
                        st_ff <= `RII_M_DELAY;
                        dCnt_ff <= {`RII_DLY_W{1'b0}};
                    end else begin
                        case (st_ff)
                            `RII_M_IDLE: begin
                                dCnt_ff <= {`RII_DLY_W{1'b0}};
                            end
                            `RII_M_DELAY: begin
                                if (readEn) begin
                                    if (dCnt_ff == dTarget - 12'h001) begin
                                        st_ff <= `RII_M_INTEG;
                                        acc_ff <= {`RII_ACC_W{1'b0}};
                                        iCnt_ff <= {`RII_CNT_W{1'b0}};
                                        vCnt_ff <= {`RII_CNT_W{1'b0}};
                                    end else begin
                                        dCnt_ff <= dCnt_ff + 12'h001;
                                    end
                                end
                            end
                            `RII_M_INTEG: begin
                                if (readEn) begin
                                    acc_ff <= accNext;
                                    iCnt_ff <= iCnt_ff + 24'h000001;
                                    vCnt_ff <= vCnt_ff + 24'h000001;
                                    if (iCnt_ff == iTarget) begin
                                        res_ff <= accNext;
                                        done_ff <= 1'b1;
                                        st_ff <= `RII_M_WAIT;
                                    end
                                end
                            end
                            `RII_M_WAIT: begin
                                if (readEn) begin
                                    if (vCnt_ff == vTarget - 24'h000001) begin
                                        st_ff <= `RII_M_INTEG;
                                        acc_ff <= {`RII_ACC_W{1'b0}};
                                        iCnt_ff <= {`RII_CNT_W{1'b0}};
                                        vCnt_ff <= {`RII_CNT_W{1'b0}};
                                    end else begin
                                        vCnt_ff <= vCnt_ff + 24'h000001;
                                    end
                                end
                            end
                            default: begin
                                st_ff <= `RII_M_IDLE;
                            end
                        endcase
                    end
                end
            end
            assign powerResult[m*58 +: 58] = res_ff;
            assign powerReady[m] = done_ff;
        end
    endgenerate
endmodule

// [rtl/rii_defines.vh]
// Shared constants for the receive input interface
`ifndef RII_DEFINES_VH
`define RII_DEFINES_VH
// Converter ports and sample width
`define RII_PORTS 4
`define RII_SW 16
// Receive FIFO pointer reload values
`define RII_WP_INIT 3'h4
`define RII_RP_INIT 3'h0
// Read rate masks for divide by 1, 2, 4, 8
`define RII_MASK_D1 3'h0
`define RII_MASK_D2 3'h1
`define RII_MASK_D4 3'h3
`define RII_MASK_D8 3'h7
// Output buffer shape
`define RII_OB_WIDTH 64
`define RII_OB_DEPTH 32
`define RII_OB_AW 5
`define RII_OB_ROOM 7'h20
// Meter widths and timing constants
`define RII_ACC_W 58
`define RII_CNT_W 24
`define RII_DLY_W 12
`define RII_STEP_SH 3'h0
`define RII_DLY_EXTRA 12'h002
// Meter states
`define RII_M_IDLE 2'h0
`define RII_M_DELAY 2'h1
`define RII_M_INTEG 2'h2
`define RII_M_WAIT 2'h3
`endif

// [rtl/rii_fifo.v]
// Valid/ready buffer for the output sample stream
`timescale 1ns/100ps
module rii_fifo #(
    parameter WIDTH = 64,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Fill side
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    // Drain side
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    // Storage and pointers
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_ff;
    reg [AW-1:0] rdPtr_ff;
    reg [AW:0] count_ff;
    wire doPush;
    wire doPop;

    // Honest full and empty from the count
    assign inReady = (count_ff != DEPTH[AW:0]);
    assign outValid = (count_ff != {(AW+1){1'b0}});
    assign doPush = inValid & inReady;
    assign doPop = outValid & outReady;
    assign outData = mem[rdPtr_ff];

    // Storage write, no reset needed for data
    always @(posedge sys_clk) begin
        if (doPush) begin
            mem[wrPtr_ff] <= inData;
        end
    end

    // Pointer and count update
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_ff <= {AW{1'b0}};
            rdPtr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else begin
            if (doPush) begin
                wrPtr_ff <= wrPtr_ff + {{(AW-1){1'b0}}, 1'b1};
            end
            if (doPop) begin
                rdPtr_ff <= rdPtr_ff + {{(AW-1){1'b0}}, 1'b1};
            end
            if (doPush && !doPop) begin
                count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
            end else if (doPop && !doPush) begin
                count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule

// [test/rii_receive_input_chk.sv]
// Port-level assertion checker for the receive input interface
`timescale 1ns/100ps
module rii_receive_input_chk (
    // Clock and reset
    input logic sys_clk,
    input logic rst_n,
    // Watched inputs
    input logic [7:0] syncPins,
    input logic [2:0] downconverterSyncPick,
    input logic testBusOn,
    input logic [3:0] meterOnFlag,
    input logic dataReady,
    // Watched outputs
    input logic testBusOe,
    input logic [231:0] powerResult,
    input logic [3:0] powerReady,
    input logic downconverterSync_ff,
    input logic dataValid,
    input logic [63:0] dataOut
);
    // One clock domain, so one clocking and one disable for all
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_oe_follows: assert property (testBusOe == testBusOn)
        else $error("test bus enable does not follow test bus on");
    a_dsync_single: assert property (downconverterSync_ff |=> !downconverterSync_ff)
        else $error("downconverter sync longer than one cycle");
    // Pins are held for several cycles, so a depth of 3 lands inside the pulse
    a_dsync_cause: assert property (downconverterSync_ff |-> $past(syncPins[downconverterSyncPick], 3))
        else $error("downconverter sync without picked pin");
    a_ready_gap: assert property (powerReady[0] |=> !powerReady[0] [*5])
        else $error("meter 0 results too close together");
    a_ready_pulse: assert property (powerReady[1] |=> !powerReady[1])
        else $error("meter 1 ready longer than one cycle");
    a_result_hold: assert property (!powerReady[0] |-> $stable(powerResult[57:0]))
        else $error("meter 0 result changed without ready");
    a_meter_idle: assert property (!meterOnFlag[2] && $past(!meterOnFlag[2]) |-> !powerReady[2])
        else $error("meter 2 produced a result while off");
    // Stalled words must not slip away under the consumer
    a_stream_hold: assert property (dataValid && !dataReady |=> dataValid && $stable(dataOut))
        else $error("stream word changed while stalled");
endmodule

bind rii_receive_input rii_receive_input_chk i_chk (
    .sys_clk, .rst_n, .syncPins, .downconverterSyncPick, .testBusOn, .meterOnFlag,
    .dataReady, .testBusOe, .powerResult, .powerReady, .downconverterSync_ff,
    .dataValid, .dataOut
);

// [test/rii_adc_model.sv]
// Converter model: four sample clocks and held sample words
`timescale 1ns/100ps
module rii_adc_model (
    // Control from the bench
    input logic run,
    input logic [63:0] level,
    // Converter pins
    output logic [3:0] adcClk,
    output logic [63:0] adcData
);
    logic conv = 1'b0; // Internal converter clock, odd phase against sys_clk

    // 320 ns period keeps the converter slower than the receive clock
    initial begin
        #7;
        forever #160 conv = ~conv;
    end

    // Clock pins stand still while the converter is stopped
    assign adcClk = run ? {4{conv}} : 4'h0;

    // New word on the falling edge so it is settled at the rising edge
    always @(negedge conv) begin
        adcData <= level;
    end
    initial adcData = 64'h0;
endmodule

// [test/rii_receive_input_tb.sv]
// Self-checking bench for the receive input interface
`timescale 1ns/100ps
module rii_receive_input_tb;
    // Clock, reset and tallies
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    int miscompares = 0;
    int checks = 0;
    // Converter model control and pins
    logic run = 1'b1;
    logic [63:0] level = 64'h0;
    logic [3:0] adcClk;
    logic [63:0] adcData;
    // Format, FIFO and sync control
    logic [7:0] syncPins = 8'h00;
    logic [3:0] unsignedFormatFlag = 4'h0;
    logic [11:0] topBitPlace = 12'h000;
    logic [1:0] fifoSpeedChoice = 2'h3;
    logic fifoSkipFlag = 1'b0;
    logic pairLockFirst = 1'b1;
    logic pairLockSecond = 1'b1;
    logic [2:0] fifoSyncPick = 3'h0;
    logic [2:0] downconverterSyncPick = 3'h0;
    logic [23:0] delayLength = 24'h041041;
    logic testBusOn = 1'b0;
    logic testBusPick = 1'b0;
    // Meter setup: meter0 complex on ports 0/1, meter1 port 2, meter2 port 0
    logic [3:0] meterOnFlag = 4'h0;
    logic [3:0] meterComplexFlag = 4'h1;
    logic [7:0] meterISel = 8'h08;
    logic [7:0] meterQSel = 8'h01;
    logic [83:0] integrationLength = {21'd0, 21'd0, 21'd2, 21'd1};
    logic [83:0] meterRepeatInterval = {21'd0, 21'd1, 21'd4, 21'd4};
    logic [35:0] meterStartDelay = {9'd0, 9'd0, 9'd1, 9'd1};
    logic [11:0] meterSyncPick = 12'h092;
    // Outputs and stream
    logic [31:0] testBusData_ff;
    logic [31:0] busAtSync; // Test bus seen just after a sync
    logic testBusOe;
    logic [231:0] powerResult;
    logic [3:0] powerReady;
    logic downconverterSync_ff;
    logic dataValid;
    logic dataReady = 1'b1;
    logic [63:0] dataOut;

    always #20 sys_clk = ~sys_clk;

    rii_adc_model i_adc (.run, .level, .adcClk, .adcData);

    rii_receive_input i_dut (
        .sys_clk, .rst_n, .adcClk, .adcData, .syncPins, .unsignedFormatFlag, .topBitPlace,
        .fifoSpeedChoice, .fifoSkipFlag, .pairLockFirst, .pairLockSecond, .fifoSyncPick,
        .downconverterSyncPick, .delayLength, .testBusOn, .testBusPick, .testBusData_ff,
        .testBusOe, .meterOnFlag, .meterComplexFlag, .meterISel, .meterQSel,
        .integrationLength, .meterRepeatInterval, .meterStartDelay, .meterSyncPick,
        .powerResult, .powerReady, .downconverterSync_ff, .dataValid, .dataReady, .dataOut
    );

    // Compare and tally
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic end_of_test;
        $display("checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Hold a sync pin high for six cycles, counting downconverter sync pulses
    task automatic pulse(input int i, output int n);
        n = 0;
        syncPins[i] = 1'b1;
        for (int k = 0; k < 14; k++) begin
            @(negedge sys_clk);
            if (k == 5) syncPins[i] = 1'b0;
            if (k == 3) busAtSync = testBusData_ff;
            if (downconverterSync_ff === 1'b1) n++;
        end
    endtask

    // Bounded wait for a meter result; returns cycles waited
    task automatic wait_ready(input int i, output int t);
        for (t = 1; t <= 4000; t++) begin
            @(negedge sys_clk);
            if (powerReady[i] === 1'b1) return;
        end
        miscompares++;
        end_of_test();
    endtask

    // Every pick value selects its own pin and ignores pin p^1
    task automatic t_sync;
        int n;
        testBusPick = 1'b1;
        for (int p = 0; p < 8; p++) begin
            downconverterSyncPick = p[2:0];
            fifoSyncPick = p[2:0];
            pulse(p, n);
            check("sync picked", n, 1);
            check("fifo sync pointers", busAtSync, 32'h0092_4000);
            pulse(p ^ 1, n);
            check("sync other", n, 0);
            check("fifo sync other", busAtSync == 32'h0092_4000, 0);
        end
        testBusPick = 1'b0;
    endtask

    // Bypass capture, format flag and top bit place seen on the test bus
    task automatic t_format;
        logic [15:0] e;
        fifoSkipFlag = 1'b1;
        testBusOn = 1'b1;
        level = {32'hffff_ffff, 16'h00c3, 16'h1234};
        for (int v = 0; v < 8; v++) begin
            topBitPlace = {9'h0, v[2:0]} << 3;
            unsignedFormatFlag = {2'h0, v[0], 1'b1};
            e = (16'h00c3 << v) ^ (v[0] ? 16'h8000 : 16'h0);
            cyc(40);
            check("port1 formatted", testBusData_ff[31:16], e);
            check("port0 formatted", testBusData_ff[15:0], 16'h9234);
            check("bus enable", testBusOe, 1);
            for (int k = 0; k < 16 && dataValid !== 1'b1; k++) cyc(1);
            check("stream word", dataValid, 1);
            check("ports 2,3 silent", dataOut[63:32], 0);
        end
        testBusOn = 1'b0;
        topBitPlace = 12'h000;
        unsignedFormatFlag = 4'h0;
    endtask

    // A step on ports 0 and 1 together; count words until port 0 follows
    task automatic t_delay(input logic [5:0] d);
        int n;
        bit seen;
        bit done;
        n = 0;
        seen = 0;
        done = 0;
        level = 64'h0;
        delayLength = {18'h01041, d};
        cyc(700);
        level = {32'h0, 16'h0001, 16'h0001};
        for (int k = 0; k < 1200 && !done; k++) begin
            @(negedge sys_clk);
            if (dataValid === 1'b1 && (seen || dataOut[16] === 1'b1)) begin
                seen = 1;
                if (dataOut[0] === 1'b1) done = 1;
                else n++;
            end
        end
        check("delay words", n, (d == 0) ? 63 : d - 1);
    endtask

    // Meters through the converter FIFOs with pair locks on
    task automatic t_meter;
        int t;
        fifoSkipFlag = 1'b0;
        fifoSyncPick = 3'h0;
        fifoSpeedChoice = 2'h3;
        level = {16'h0000, 16'h0300, 16'hff00, 16'h0123};
        cyc(80);
        pulse(0, t);
        meterOnFlag = 4'h3;
        pulse(2, t);
        wait_ready(0, t);
        check("complex power", powerResult[57:0], (291 * 291 + 256 * 256) * 9);
        wait_ready(1, t);
        check("real power", powerResult[115:58], 768 * 768 * 17);
    endtask

    // Result spacing for every read rate code
    task automatic t_interval;
        int t;
        meterOnFlag = 4'h4;
        for (int s = 0; s < 4; s++) begin
            fifoSpeedChoice = s[1:0];
            pulse(2, t);
            wait_ready(2, t);
            wait_ready(2, t);
            check("interval cycles", t, 8 * (1 << s));
        end
        meterOnFlag = 4'h0;
        cyc(100);
    endtask

    // Stall the stream until the buffer refuses, then drain it
    task automatic t_fill;
        int n;
        n = 0;
        fifoSpeedChoice = 2'h0;
        dataReady = 1'b0;
        cyc(200);
        check("stalled valid", dataValid, 1);
        dataReady = 1'b1;
        for (int k = 0; k < 40; k++) begin
            @(negedge sys_clk);
            if (dataValid === 1'b1) n++;
        end
        check("drained words", n, 40);
    endtask

    // Main sequence
    initial begin
        cyc(10);
        rst_n = 1'b1;
        cyc(3);
        t_sync();
        t_format();
        t_delay(6'd5);
        t_delay(6'd0);
        t_meter();
        t_interval();
        t_fill();
        end_of_test();
    end
endmodule
